//--- core/serial_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two equal to 2**AW.
`timescale 1ns/1ps
module serial_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready  = (count_r != FULL);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

//--- core/serial_status_bitrate.v
// Serial port status flags, bit-rate generator, transmit and receive
// engines, behind an Avalon-MM slave with waitrequest.
// Assumes rxd synchronous to sys_clk; standby held high in low power.
//
// Summary of operation
// - Parity mismatch on received character sets error
// - Error clears by zero write after read
// - Receive disable leaves parity error untouched
// - Parity error loads buffer, full flag unchanged
// - Error halts reception; sync also halts transmit
// - Transmit end is read only, resets one
// - Empty clear or data write clears end
// - Set end on disable or last bit
// - Capture received multiprocessor bit, read only
// - Receive disable keeps received multiprocessor bit
// - Append transmit multiprocessor bit when enabled
// - Bit rate from divisor and prescaled clock
// - Divisor readable and writable at any time
// - Divisor resets to ff, also standby
// - Async bit: 64 times prescale times N+1
// - Sync bit: 8 times prescale times N+1
// - Clock select picks divide 1,4,16,64
`timescale 1ns/1ps
`include "serial_status_defines.vh"
module serial_status_bitrate (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        standby,
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [31:0] writedata,
  output wire [31:0] readdata,
  output wire        waitrequest,
  input  wire        rxd,
  output wire        txd,
  output wire        sck,
  output wire        sck_oe
);
  function sel;
    input [4:0] a;
    input [4:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  function [5:0] pre_mask;
    input [1:0] cks;
    begin
      case (cks)
        2'b00:   pre_mask = 6'h00;
        2'b01:   pre_mask = 6'h03;
        2'b10:   pre_mask = 6'h0f;
        default: pre_mask = 6'h3f;
      endcase
    end
  endfunction

  reg  [7:0]  divisor_r;
  reg  [7:0]  mode_r;
  reg  [7:0]  ctrl_r;
  reg         tx_mp_r;
  reg         transmit_empty_flag_r;
  reg         receive_full_flag_r;
  reg         per_r;
  reg         transmit_end_flag_r;
  reg         rx_multiproc_bit_r;
  reg         seen_transmit_empty_flag_r;
  reg         seen_receive_full_flag_r;
  reg         seen_per_r;
  reg  [7:0]  rx_buf_r;
  reg         ack_r;
  reg  [31:0] readdata_r;
  reg  [5:0]  pre_cnt_r;
  reg  [7:0]  div_cnt_r;
  reg         tx_busy_r;
  reg  [11:0] tx_sh_r;
  reg  [3:0]  tx_left_r;
  reg  [6:0]  tx_tcnt_r;
  reg         txd_r;
  reg         sck_r;
  reg         rx_busy_r;
  reg  [6:0]  rx_tcnt_r;
  reg  [3:0]  rx_idx_r;
  reg  [11:0] rx_bits_r;
  reg         rxd_d_r;
  reg  [31:0] rdata_nxt;
  reg  [11:0] frame;
  reg  [3:0]  flen;
  reg         tx_x;
  reg  [7:0]  rx_word;
  reg         rx_x;

  wire        te       = ctrl_r[`CT_TX_EN];
  wire        re       = ctrl_r[`CT_RX_EN];
  wire        sync_m   = mode_r[`MD_SYNC];
  wire        seven    = mode_r[`MD_SEVEN];
  wire        par_en   = mode_r[`MD_PAR_EN];
  wire        par_odd  = mode_r[`MD_PAR_ODD];
  wire        mp_en    = mode_r[`MD_MP_EN];
  wire        has_x    = mp_en | par_en;
  wire [3:0]  ndat     = seven ? 4'h7 : 4'h8;
  wire [7:0]  status   = {transmit_empty_flag_r, receive_full_flag_r, 2'b00, per_r, transmit_end_flag_r,
                          rx_multiproc_bit_r, tx_mp_r};
  wire        q_in_ready;
  wire        q_out_valid;
  wire        q_out_ready;
  wire [7:0]  q_out_data;

  ////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, longer while the transmit queue is full

  wire req      = read | write;
  wire txd_hit  = sel(address, `OFS_TXDATA);
  wire q_push   = write & ack_r & byteenable[0] & txd_hit;
  wire blocked  = q_push & ~q_in_ready;
  wire go       = req & ack_r & ~blocked;
  wire wr       = write & go & byteenable[0];
  wire rd       = read & go;
  wire wr_st    = wr & sel(address, `OFS_STATUS);
  wire rd_st    = rd & sel(address, `OFS_STATUS);
  wire rd_rx    = rd & sel(address, `OFS_RXDATA);

  assign waitrequest = req & ~go;
  assign readdata    = readdata_r;

  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (address)
      `OFS_STATUS:  rdata_nxt[7:0] = status;
      `OFS_DIVISOR: rdata_nxt[7:0] = divisor_r;
      `OFS_MODE:    rdata_nxt[7:0] = mode_r;
      `OFS_CTRL:    rdata_nxt[7:0] = ctrl_r;
      `OFS_RXDATA:  rdata_nxt[7:0] = rx_buf_r;
      default:      rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~go;
      if (req & ~ack_r) begin
        readdata_r <= rdata_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bit-rate generator

  wire [5:0] pmask    = pre_mask(mode_r[`MD_CKS_HI:`MD_CKS_LO]);
  wire       pre_tick = ((pre_cnt_r & pmask) == pmask);
  wire       brg_tick = pre_tick & (div_cnt_r == 8'h00);
  wire [6:0] bit_ticks = sync_m ? `SYNC_TICKS : `ASYNC_TICKS;
  wire [6:0] last_tick = bit_ticks - 7'h01;
  wire [6:0] half_tick = {1'b0, bit_ticks[6:1]};
  wire       tx_load   = q_out_valid & q_out_ready;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_r <= 6'h00;
      div_cnt_r <= 8'h00;
    end else if (tx_load) begin
      // Restart on load so the first bit of a frame is full length
      pre_cnt_r <= 6'h00;
      div_cnt_r <= divisor_r;
    end else begin
      pre_cnt_r <= pre_cnt_r + 6'h01;
      if (pre_tick) begin
        div_cnt_r <= (div_cnt_r == 8'h00) ? divisor_r
                                          : div_cnt_r - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit queue and shifter

  serial_fifo #(
    .WIDTH (`TXQ_WIDTH),
    .DEPTH (`TXQ_DEPTH),
    .AW    (`TXQ_AW)
  ) u_txq (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .flush     (standby),
    .in_valid  (q_push),
    .in_ready  (q_in_ready),
    .in_data   (writedata[7:0]),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out_data)
  );

  assign q_out_ready = te & ~tx_busy_r & ~(sync_m & per_r);
  wire tx_done = tx_busy_r & brg_tick & (tx_tcnt_r == last_tick) &
                 (tx_left_r == 4'h1);

  always @* begin
    tx_x = mp_en ? tx_mp_r
                 : par_odd ^ (^(q_out_data & {~seven, 7'h7f}));
    if (sync_m) begin
      frame = {4'hf, q_out_data};
      flen  = 4'h8;
    end else begin
      if (seven) begin
        frame = {3'h7, has_x ? tx_x : 1'b1, q_out_data[6:0], 1'b0};
      end else begin
        frame = {2'h3, has_x ? tx_x : 1'b1, q_out_data, 1'b0};
      end
      flen = 4'h2 + ndat + {3'b000, has_x} +
             {3'b000, mode_r[`MD_TWO_STOP]};
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 12'hfff;
      tx_left_r <= 4'h0;
      tx_tcnt_r <= 7'h00;
      txd_r     <= 1'b1;
      sck_r     <= 1'b1;
    end else if (~te) begin
      tx_busy_r <= 1'b0;
      tx_tcnt_r <= 7'h00;
      txd_r     <= 1'b1;
      sck_r     <= 1'b1;
    end else begin
      txd_r <= tx_busy_r ? tx_sh_r[0] : 1'b1;
      sck_r <= ~(tx_busy_r & sync_m & (tx_tcnt_r < half_tick));
      if (tx_load) begin
        tx_busy_r <= 1'b1;
        tx_sh_r   <= frame;
        tx_left_r <= flen;
        tx_tcnt_r <= 7'h00;
      end else if (tx_busy_r & brg_tick) begin
        if (tx_tcnt_r == last_tick) begin
          tx_tcnt_r <= 7'h00;
          tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
          tx_left_r <= tx_left_r - 4'h1;
          if (tx_left_r == 4'h1) begin
            tx_busy_r <= 1'b0;
          end
        end else begin
          tx_tcnt_r <= tx_tcnt_r + 7'h01;
        end
      end
    end
  end

  assign txd    = txd_r;
  assign sck    = sck_r;
  assign sck_oe = sync_m;

  ////////////////////////////////////////////////////////////////////
  // Receiver: async samples mid-bit, sync samples on the clock rise

  wire [3:0] rx_last  = ndat + {3'b000, has_x} + 4'h1;
  wire       rx_samp  = rx_busy_r & brg_tick & (rx_tcnt_r == last_tick);
  wire       rx_start = re & ~sync_m & ~per_r & ~rx_busy_r &
                        rxd_d_r & ~rxd;
  wire       a_fin    = rx_samp & (rx_idx_r == rx_last);
  wire       s_samp   = sync_m & re & ~per_r & tx_busy_r & brg_tick &
                        (tx_tcnt_r == half_tick - 7'h01);
  wire       s_fin    = s_samp & (rx_idx_r == 4'h7);
  wire       rx_fin   = a_fin | s_fin;

  always @* begin
    if (sync_m) begin
      rx_word = {rxd, rx_bits_r[7:1]};
      rx_x    = 1'b0;
    end else if (seven) begin
      rx_word = {1'b0, rx_bits_r[7:1]};
      rx_x    = rx_bits_r[8];
    end else begin
      rx_word = rx_bits_r[8:1];
      rx_x    = rx_bits_r[9];
    end
  end

  wire par_bad = a_fin & par_en & ~mp_en &
                 ((^rx_word ^ rx_x) != par_odd);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_busy_r <= 1'b0;
      rx_tcnt_r <= 7'h00;
      rx_idx_r  <= 4'h0;
      rx_bits_r <= 12'h000;
      rxd_d_r   <= 1'b1;
    end else begin
      rxd_d_r <= rxd;
      if (~re | sync_m) begin
        rx_busy_r <= 1'b0;
        if (tx_load | ~re) begin
          rx_idx_r <= 4'h0;
        end else if (s_samp) begin
          rx_bits_r[rx_idx_r + 4'h1] <= rxd;
          rx_idx_r <= rx_idx_r + 4'h1;
        end
      end else if (rx_start) begin
        rx_busy_r <= 1'b1;
        rx_tcnt_r <= half_tick;
        rx_idx_r  <= 4'h0;
      end else if (rx_busy_r & brg_tick) begin
        if (rx_samp) begin
          rx_tcnt_r <= 7'h00;
          rx_bits_r[rx_idx_r] <= rxd;
          rx_idx_r  <= rx_idx_r + 4'h1;
          if (((rx_idx_r == 4'h0) & rxd) | a_fin) begin
            rx_busy_r <= 1'b0;
          end
        end else begin
          rx_tcnt_r <= rx_tcnt_r + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers and status flags; hardware set wins over software clear

  wire clr_transmit_empty_flag = wr_st & ~writedata[`ST_TX_EMPTY] & seen_transmit_empty_flag_r;
  wire clr_receive_full_flag = wr_st & ~writedata[`ST_RX_FULL] & seen_receive_full_flag_r;
  wire clr_per  = wr_st & ~writedata[`ST_PAR_ERR] & seen_per_r;
  wire tdb_wr   = wr & txd_hit;
  wire set_transmit_empty_flag = ~te | tx_load;
  wire set_receive_full_flag = rx_fin & ~par_bad & ~receive_full_flag_r;
  wire set_transmit_end_flag = ~te | (tx_done & transmit_empty_flag_r);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divisor_r   <= `RST_DIVISOR;
      mode_r      <= `RST_MODE;
      ctrl_r      <= `RST_CTRL;
      tx_mp_r     <= 1'b0;
      transmit_empty_flag_r      <= 1'b1;
      receive_full_flag_r      <= 1'b0;
      per_r       <= 1'b0;
      transmit_end_flag_r      <= 1'b1;
      rx_multiproc_bit_r      <= 1'b0;
      seen_transmit_empty_flag_r <= 1'b0;
      seen_receive_full_flag_r <= 1'b0;
      seen_per_r  <= 1'b0;
      rx_buf_r    <= 8'h00;
    end else if (standby) begin
      divisor_r   <= `RST_DIVISOR;
      mode_r      <= `RST_MODE;
      ctrl_r      <= `RST_CTRL;
      tx_mp_r     <= 1'b0;
      transmit_empty_flag_r      <= 1'b1;
      receive_full_flag_r      <= 1'b0;
      per_r       <= 1'b0;
      transmit_end_flag_r      <= 1'b1;
      rx_multiproc_bit_r      <= 1'b0;
      seen_transmit_empty_flag_r <= 1'b0;
      seen_receive_full_flag_r <= 1'b0;
      seen_per_r  <= 1'b0;
    end else begin
      if (wr & sel(address, `OFS_DIVISOR)) begin
        divisor_r <= writedata[7:0];
      end
      if (wr & sel(address, `OFS_MODE)) begin
        mode_r <= writedata[7:0];
      end
      if (wr & sel(address, `OFS_CTRL)) begin
        ctrl_r <= writedata[7:0] & 8'h30;
      end
      if (wr_st) begin
        tx_mp_r <= writedata[`ST_TX_MP];
      end
      // Flags: set has priority; writing one never sets
      transmit_empty_flag_r <= set_transmit_empty_flag | (transmit_empty_flag_r & ~clr_transmit_empty_flag & ~tdb_wr);
      receive_full_flag_r <= set_receive_full_flag | (receive_full_flag_r & ~clr_receive_full_flag & ~rd_rx);
      per_r  <= par_bad | (per_r & ~clr_per);
      transmit_end_flag_r <= set_transmit_end_flag | (transmit_end_flag_r & ~clr_transmit_empty_flag & ~tdb_wr);
      seen_transmit_empty_flag_r <= (seen_transmit_empty_flag_r & ~clr_transmit_empty_flag & ~tdb_wr) |
                     (rd_st & readdata_r[`ST_TX_EMPTY]);
      seen_receive_full_flag_r <= (seen_receive_full_flag_r & ~clr_receive_full_flag & ~rd_rx) |
                     (rd_st & readdata_r[`ST_RX_FULL]);
      seen_per_r  <= (seen_per_r & ~clr_per) |
                     (rd_st & readdata_r[`ST_PAR_ERR]);
      if (par_bad | set_receive_full_flag) begin
        rx_buf_r <= rx_word;
      end
      if (a_fin & mp_en) begin
        rx_multiproc_bit_r <= rx_x;
      end
    end
  end
endmodule

//--- dv/serial_peer.sv
// Serial peer that drives the receive line of the block.
// Assumes the caller gives the bit time in system clock cycles.
`timescale 1ns/1ps
module serial_peer (
  input wire sys_clk,
  output reg rxd
);
  initial rxd = 1'b1;
  // Start, eight data bits LSB first, parity or address bit, stop; idle high after
  task automatic send(input logic [7:0] d, input logic x, input int cyc);
    logic [10:0] f;
    f = {1'b1, x, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk);
      rxd <= f[i];
      repeat (cyc - 1) @(posedge sys_clk);
    end
  endtask
endmodule

//--- dv/serial_status_bitrate_test.sv
// Self-checking bench for the serial status and bit-rate block.
// Assumes the block's define header and the serial peer model.
`timescale 1ns/1ps
`include "serial_status_defines.vh"
module serial_status_bitrate_test;
  logic        sys_clk;
  logic        rst;
  logic        standby;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  wire  [31:0] readdata;
  wire         waitrequest;
  wire         rxd;
  wire         txd;
  wire         sck;
  wire         sck_oe;
  int          fails;
  int          comparisons;
  int          cycles;
  int          waits;
  int          rises;
  int          len;
  logic [7:0]  q;
  logic [7:0]  n;
  logic [7:0]  d;
  logic [7:0]  e;
  serial_status_bitrate dut_u (
    .sys_clk(sys_clk), .rst(rst), .standby(standby), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxd(rxd), .txd(txd), .sck(sck), .sck_oe(sck_oe));
  serial_peer peer_u (.sys_clk(sys_clk), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      fails++;
      complete_run();
    end
  end
  always @(posedge sck) rises++;
  ////////////////////////////////////////////////////////////////////
  function automatic int bit_len(input int ticks, input logic [7:0] dv, input int c);
    return (ticks * (dv + 1)) << (2 * c);
  endfunction
  function automatic logic par_bit(input logic [7:0] dv, input logic odd);
    return ^dv ^ odd;
  endfunction
  task complete_run();
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      fails++;
    end
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, v};
    waits = 0;
    do begin
      @(posedge sys_clk);
      waits++;
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rchk(input logic [4:0] a, input logic [7:0] ex, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, ex, q);
  endtask
  task low_len(input logic use_sck);
    len = 0;
    do @(negedge sys_clk); while ((use_sck ? sck : txd) !== 1'b0);
    while ((use_sck ? sck : txd) === 1'b0) begin
      @(negedge sys_clk);
      len++;
    end
  endtask
  task wait_transmit_end_flag();
    q = 8'h00;
    while (q[2] !== 1'b1) bus(1'b0, `OFS_STATUS, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    standby = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h1;
    writedata = 32'h0;
    cycles = 0;
    fails = 0;
    comparisons = 0;
    void'($urandom(32'h307445cc));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(`OFS_STATUS, 8'h84, "status reset");
    rchk(`OFS_DIVISOR, 8'hff, "divisor reset");
    rchk(5'h18, 8'h00, "unmapped");
    bus(1'b1, 5'h18, 8'h5a);
    bus(1'b1, `OFS_STATUS, 8'hff);
    rchk(`OFS_STATUS, 8'h85, "status ones");
    n = $urandom;
    bus(1'b1, `OFS_DIVISOR, n);
    rchk(`OFS_DIVISOR, n, "divisor");
    @(posedge sys_clk);
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    rchk(`OFS_DIVISOR, 8'hff, "divisor standby");
    rchk(`OFS_STATUS, 8'h84, "status standby");
    bus(1'b1, `OFS_CTRL, 8'h20);
    rchk(`OFS_STATUS, 8'h84, "status idle");
    bus(1'b1, `OFS_STATUS, 8'h00);
    rchk(`OFS_STATUS, 8'h00, "end on clear");
    bus(1'b1, `OFS_CTRL, 8'h00);
    rchk(`OFS_STATUS, 8'h84, "end on disable");
    // Async start bit length for every clock select
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 8'($urandom_range(7)) : 8'h00;
      bus(1'b1, `OFS_MODE, 8'(c));
      bus(1'b1, `OFS_DIVISOR, n);
      bus(1'b1, `OFS_CTRL, 8'h20);
      bus(1'b1, `OFS_TXDATA, 8'hff);
      low_len(1'b0);
      chk("start bit", bit_len(64, n, c), len);
      rchk(`OFS_STATUS, 8'h80, "end busy");
      wait_transmit_end_flag();
      rchk(`OFS_STATUS, 8'h84, "end done");
    end
    n = $urandom_range(15);
    bus(1'b1, `OFS_MODE, 8'h80);
    bus(1'b1, `OFS_DIVISOR, n);
    bus(1'b1, `OFS_TXDATA, 8'($urandom));
    chk("clock drive", 1'b1, sck_oe);
    low_len(1'b1);
    chk("clock low", bit_len(4, n, 0), len);
    wait_transmit_end_flag();
    // Fill the transmit queue until it stalls, then let it drain
    bus(1'b1, `OFS_MODE, 8'h81);
    bus(1'b1, `OFS_DIVISOR, 8'h00);
    rises = 0;
    for (int k = 0; k < 34; k++) begin
      bus(1'b1, `OFS_TXDATA, 8'($urandom));
      if (k == 32) chk("queue accept", 2, waits);
    end
    chk("queue refuse", 1'b1, waits > 2);
    wait (rises == 272);
    bus(1'b1, `OFS_CTRL, 8'h00);
    // Receive: even and odd parity, good and bad, then address bit
    for (int i = 0; i < 5; i++) begin
      d = $urandom;
      bus(1'b1, `OFS_MODE, (i == 4) ? 8'h04 : {3'h1, i[1], 4'h0});
      bus(1'b1, `OFS_CTRL, 8'h10);
      peer_u.send(d, (i == 4) | (par_bit(d, i[1]) ^ i[0]), 64);
      e = (i == 4) ? 8'hc6 : (i[0] ? 8'h8c : 8'hc4);
      rchk(`OFS_STATUS, e, "rx status");
      rchk(`OFS_RXDATA, d, "rx data");
      if (i[0] && i < 4) begin
        peer_u.send(~d, 1'b0, 64);
        rchk(`OFS_RXDATA, d, "rx halted");
      end
      bus(1'b1, `OFS_CTRL, 8'h00);
      rchk(`OFS_STATUS, e & 8'hbf, "rx disabled");
      bus(1'b1, `OFS_STATUS, 8'h84);
      rchk(`OFS_STATUS, e & 8'hb7, "error cleared");
    end
    // Seven-bit character with even parity; received address bit kept from above
    d = $urandom;
    d[7] = 1'b0;
    bus(1'b1, `OFS_MODE, 8'h60);
    bus(1'b1, `OFS_CTRL, 8'h10);
    peer_u.send({par_bit(d, 1'b0), d[6:0]}, 1'b1, 64);
    rchk(`OFS_STATUS, 8'hc6, "rx seven status");
    rchk(`OFS_RXDATA, d, "rx seven data");
    complete_run();
  end
endmodule

//--- dv/serial_status_checker.sv
// Port checker for the serial status block, bound to its top module.
// Assumes the offsets of the block's define header.
`timescale 1ns/1ps
`include "serial_status_defines.vh"
module serial_status_checker (
  input wire        sys_clk,
  input wire        rst,
  input wire        standby,
  input wire [4:0]  address,
  input wire        read,
  input wire        write,
  input wire [3:0]  byteenable,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire        txd,
  input wire        sck,
  input wire        sck_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  reg  [7:0] div_r;
  reg  [1:0] cks_r;
  int        low_r;
  wire       wr_ok  = write && !waitrequest && byteenable[0];
  wire       rd_ok  = read && !waitrequest;
  wire       mapped = address[1:0] == 2'h0 && address <= `OFS_RXDATA;
  // Shadow of divisor and clock select, and length of the current clock low
  always @(posedge sys_clk or posedge rst) begin
    if (rst || standby) begin
      div_r <= 8'hff;
      cks_r <= 2'h0;
    end else if (wr_ok && address == `OFS_DIVISOR) begin
      div_r <= writedata[7:0];
    end else if (wr_ok && address == `OFS_MODE) begin
      cks_r <= writedata[1:0];
    end
  end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) low_r <= 0;
    else low_r <= sck ? 0 : low_r + 1;
  end
  ////////////////////////////////////////////////////////////////////
  chk_wait_first: assert property ($rose(read) |-> waitrequest)
    else $error("read answered too soon");
  chk_wait_one: assert property (read && waitrequest |=> !waitrequest)
    else $error("read answered late");
  chk_idle_free: assert property (!read && !write |-> !waitrequest)
    else $error("wait without request");
  chk_unmapped_zero: assert property (rd_ok && !mapped |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_divisor_echo: assert property (rd_ok && address == `OFS_DIVISOR |->
    readdata == {24'h0, div_r}) else $error("divisor read wrong");
  chk_mode_drive: assert property (wr_ok && address == `OFS_MODE |=>
    sck_oe == $past(writedata[7])) else $error("clock drive wrong");
  chk_sck_half: assert property ($rose(sck) |->
    low_r == (4 * (div_r + 1)) << (2 * cks_r)) else $error("clock low time wrong");
  chk_reset_idle: assert property ($fell(rst) |-> txd && sck && !sck_oe)
    else $error("lines not idle after reset");
  cover property (rd_ok && address == `OFS_STATUS && readdata[3]);
  cover property ($rose(sck));
  cover property ((write && waitrequest) [*3]);
endmodule

bind serial_status_bitrate serial_status_checker chk_u (
  .sys_clk(sys_clk), .rst(rst), .standby(standby), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .txd(txd), .sck(sck), .sck_oe(sck_oe));

//--- pkg/serial_status_defines.vh
// Offsets, field positions, reset values and timing counts of the
// serial status and bit-rate block. Definitions only; no logic.
`ifndef SERIAL_STATUS_DEFINES_VH
`define SERIAL_STATUS_DEFINES_VH

// Byte offsets on the register bus
`define OFS_STATUS    5'h00
`define OFS_DIVISOR   5'h04
`define OFS_MODE      5'h08
`define OFS_CTRL      5'h0c
`define OFS_TXDATA    5'h10
`define OFS_RXDATA    5'h14

// Status register fields
`define ST_TX_EMPTY   7
`define ST_RX_FULL    6
`define ST_PAR_ERR    3
`define ST_TX_END     2
`define ST_RX_MP      1
`define ST_TX_MP      0

// Mode register fields
`define MD_SYNC       7
`define MD_SEVEN      6
`define MD_PAR_EN     5
`define MD_PAR_ODD    4
`define MD_TWO_STOP   3
`define MD_MP_EN      2
`define MD_CKS_HI     1
`define MD_CKS_LO     0

// Control register fields
`define CT_TX_EN      5
`define CT_RX_EN      4

// Reset values
`define RST_STATUS    8'h84
`define RST_DIVISOR   8'hff
`define RST_MODE      8'h00
`define RST_CTRL      8'h00

// Generator ticks per bit
`define ASYNC_TICKS   7'h40
`define SYNC_TICKS    7'h08

// Transmit buffer shape
`define TXQ_WIDTH     8
`define TXQ_DEPTH     32
`define TXQ_AW        5

`endif
